// ==== core/nod_pkg.sv ====
`default_nettype none
package nod_pkg;

  // bus and lane geometry
  localparam int NOD_ADDR_W = 8;
  localparam int NOD_DATA_W = 32;
  localparam int NOD_DLY_W = 9;
  localparam int NOD_SLICES = 3;
  localparam int NOD_BUS_W = 27;

  // register indices; byte address is four times the index
  localparam logic [5:0] NOD_IDX_SLICE0 = 6'h0b;
  localparam logic [5:0] NOD_IDX_SLICE1 = 6'h0c;
  localparam logic [5:0] NOD_IDX_SLICE2 = 6'h0d;
  localparam logic [5:0] NOD_IDX_COARSE = 6'h10;

  // field positions inside a slice register
  localparam int NOD_DLY_LSB = 0;
  localparam int NOD_DLY_MSB = 8;
  localparam int NOD_CRSE_BIT = 13;
  localparam int NOD_DEC_BIT = 14;
  localparam int NOD_INC_BIT = 15;

  // reset values
  localparam logic [8:0] NOD_DLY_RST = 9'h000;
  localparam logic [8:0] NOD_COARSE_RST = 9'h008;
  localparam logic [31:0] NOD_RDATA_RST = 32'h0000_0000;

  // decoded update operation
  typedef enum logic [2:0] {
    NOD_OP_LOAD        = 3'b000,
    NOD_OP_FINE_UP     = 3'b001,
    NOD_OP_FINE_DOWN   = 3'b010,
    NOD_OP_COARSE_UP   = 3'b011,
    NOD_OP_COARSE_DOWN = 3'b100
  } nod_op_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } nod_avs_req_t;

  // fabric-side load request
  typedef struct packed {
    logic [2:0] load_en;
    logic [26:0] load_bus;
  } nod_fab_load_t;

  // whole state of the register bank
  typedef struct packed {
    logic [2:0][8:0] dly;
    logic [8:0] coarse;
    logic ack;
    logic [31:0] rdata;
  } nod_state_t;

  // {coarse, down, up} command bits to operation
  function automatic nod_op_t nod_decode(input logic [2:0] cmd);
    nod_op_t op;
    op = NOD_OP_LOAD;
    unique case (cmd)
      3'b000, 3'b011, 3'b100, 3'b111: op = NOD_OP_LOAD;
      3'b001: op = NOD_OP_FINE_UP;
      3'b010: op = NOD_OP_FINE_DOWN;
      3'b101: op = NOD_OP_COARSE_UP;
      3'b110: op = NOD_OP_COARSE_DOWN;
    endcase
    return op;
  endfunction

endpackage
`default_nettype wire

// ==== core/nod_step.sv ====
`timescale 1ns/1ns
`default_nettype none
module nod_step (
  input wire nod_pkg::nod_op_t op_in,
  input wire logic [8:0] cur_in,
  input wire logic [8:0] data_in,
  input wire logic [8:0] coarse_in,
  output logic [8:0] nxt_out
);
  import nod_pkg::*;

  // next delay; 9-bit arithmetic wraps modulo 512
  always_comb begin
    nxt_out = cur_in;
    unique case (op_in)
      NOD_OP_LOAD: nxt_out = data_in;
      // one tap up, wraps to zero
      NOD_OP_FINE_UP: nxt_out = 9'(cur_in + 9'h001);
      // one tap down, wraps to top
      NOD_OP_FINE_DOWN: nxt_out = 9'(cur_in - 9'h001);
      NOD_OP_COARSE_UP: nxt_out = 9'(cur_in + coarse_in);
      NOD_OP_COARSE_DOWN: nxt_out = 9'(cur_in - coarse_in);
    endcase
  end

endmodule // nod_step
`default_nettype wire

// ==== core/nod_regs.sv ====
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module nod_regs (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire nod_pkg::nod_avs_req_t AVS_REQ_IN,
  output logic AVS_WAITREQUEST_OUT,
  output logic [31:0] AVS_READDATA_OUT,
  input wire nod_pkg::nod_fab_load_t FAB_LOAD_IN,
  output logic [26:0] FAB_READBACK_OUT
);
  import nod_pkg::*;

  nod_state_t st_ff;
  nod_state_t nxt_st;
  logic req;
  logic [5:0] idx;
  logic [2:0] hit;
  logic hit_coarse;
  logic [2:0] cmd;
  nod_op_t op;
  logic [2:0][8:0] step_dly;

  // request decode on word index
  assign req = AVS_REQ_IN.read | AVS_REQ_IN.write;
  assign idx = AVS_REQ_IN.address[7:2];
  assign hit[0] = (idx == NOD_IDX_SLICE0);
  assign hit[1] = (idx == NOD_IDX_SLICE1);
  assign hit[2] = (idx == NOD_IDX_SLICE2);
  assign hit_coarse = (idx == NOD_IDX_COARSE);

  assign cmd = {AVS_REQ_IN.writedata[NOD_CRSE_BIT], AVS_REQ_IN.writedata[NOD_DEC_BIT],
                AVS_REQ_IN.writedata[NOD_INC_BIT]};
  assign op = nod_decode(cmd);

  // one update unit per slice
  for (genvar g = 0; g < NOD_SLICES; g++) begin : g_step
    nod_step u_step (
      .op_in(op),
      .cur_in(st_ff.dly[g]),
      .data_in(AVS_REQ_IN.writedata[NOD_DLY_MSB:NOD_DLY_LSB]),
      .coarse_in(st_ff.coarse),
      .nxt_out(step_dly[g])
    );
  end

  // handshake: one wait cycle, then accept
  assign AVS_WAITREQUEST_OUT = req & ~st_ff.ack;
  assign AVS_READDATA_OUT = st_ff.rdata;

  // readback lanes come straight from the delay flops
  assign FAB_READBACK_OUT = {st_ff.dly[2], st_ff.dly[1], st_ff.dly[0]};

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req & ~st_ff.ack;
    // read capture in the wait cycle; unmapped reads give zero
    if (AVS_REQ_IN.read && !st_ff.ack) begin
      nxt_st.rdata = NOD_RDATA_RST;
      for (int i = 0; i < NOD_SLICES; i++) begin
        // command bits and reserved bits read zero
        if (hit[i]) begin
          nxt_st.rdata[NOD_DLY_MSB:NOD_DLY_LSB] = st_ff.dly[i];
        end
      end
      if (hit_coarse) begin
        nxt_st.rdata[NOD_DLY_MSB:NOD_DLY_LSB] = st_ff.coarse;
      end
    end
    for (int i = 0; i < NOD_SLICES; i++) begin
      // fabric lane load, bus write wins if both land together
      if (FAB_LOAD_IN.load_en[i]) begin
        nxt_st.dly[i] = FAB_LOAD_IN.load_bus[i*NOD_DLY_W +: NOD_DLY_W];
      end
      // write takes effect at the accepting edge
      if (AVS_REQ_IN.write && st_ff.ack && hit[i]) begin
        nxt_st.dly[i] = step_dly[i];
      end
    end
    // coarse step amount, plain read/write
    if (AVS_REQ_IN.write && st_ff.ack && hit_coarse) begin
      nxt_st.coarse = AVS_REQ_IN.writedata[NOD_DLY_MSB:NOD_DLY_LSB];
    end
  end

  // state register
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_ff.dly <= {NOD_SLICES{NOD_DLY_RST}};
      st_ff.coarse <= NOD_COARSE_RST;
      st_ff.ack <= 1'b0;
      st_ff.rdata <= NOD_RDATA_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  // accepted write to one slice with a given command, lane not fabric loaded
  sequence s_wr0(logic [2:0] c);
    AVS_REQ_IN.write && !AVS_WAITREQUEST_OUT && hit[0] && cmd == c && !FAB_LOAD_IN.load_en[0];
  endsequence

  sequence s_wr1(logic [2:0] c);
    AVS_REQ_IN.write && !AVS_WAITREQUEST_OUT && hit[1] && cmd == c && !FAB_LOAD_IN.load_en[1];
  endsequence

  sequence s_wr2(logic [2:0] c);
    AVS_REQ_IN.write && !AVS_WAITREQUEST_OUT && hit[2] && cmd == c && !FAB_LOAD_IN.load_en[2];
  endsequence

  // any accepted write
  sequence s_wr_take;
    AVS_REQ_IN.write && !AVS_WAITREQUEST_OUT;
  endsequence

  // any accepted read
  sequence s_rd_take;
    AVS_REQ_IN.read && !AVS_WAITREQUEST_OUT;
  endsequence

  a_reset_zero: assert property (@(posedge SYS_CLK_IN) disable iff (1'b0)
    $past(SYS_RST_IN) |-> FAB_READBACK_OUT == 27'h0000000)
    else $error("delay not zero after reset");

  // coarse amount at its reset value
  a_reset_coarse: assert property (@(posedge SYS_CLK_IN) disable iff (1'b0)
    $past(SYS_RST_IN) |-> st_ff.coarse == NOD_COARSE_RST)
    else $error("coarse amount not at reset value");

  // read of slice 0 matches its readback lane
  a_read_live0: assert property (s_rd_take ##0 hit[0] |->
    AVS_READDATA_OUT[8:0] == $past(FAB_READBACK_OUT[8:0]))
    else $error("slice 0 read differs from readback lane");

  // read of slice 1 matches its readback lane
  a_read_live: assert property (s_rd_take ##0 hit[1] |->
    AVS_READDATA_OUT[8:0] == $past(FAB_READBACK_OUT[17:9]))
    else $error("slice 1 read differs from readback lane");

  // read of slice 2 matches its readback lane
  a_read_live2: assert property (s_rd_take ##0 hit[2] |->
    AVS_READDATA_OUT[8:0] == $past(FAB_READBACK_OUT[26:18]))
    else $error("slice 2 read differs from readback lane");

  // command and reserved bits read zero
  a_read_upper: assert property (s_rd_take ##0 (hit != 3'b000) |->
    AVS_READDATA_OUT[31:9] == 23'h000000)
    else $error("upper read bits not zero");

  a_read_unmapped: assert property (s_rd_take ##0 (hit == 3'b000 && !hit_coarse) |->
    AVS_READDATA_OUT == 32'h00000000)
    else $error("unmapped read not zero");

  a_coarse_read: assert property (s_rd_take ##0 hit_coarse |->
    AVS_READDATA_OUT == {23'h000000, $past(st_ff.coarse)})
    else $error("coarse amount read wrong");

  a_coarse_write: assert property (s_wr_take ##0 hit_coarse |=>
    st_ff.coarse == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("coarse amount write wrong");

  a_load_plain0: assert property (s_wr0(3'b000) |=>
    FAB_READBACK_OUT[8:0] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 0 load 000 wrong");

  // slice 0 load with both step bits
  a_load_direct: assert property (s_wr0(3'b011) |=>
    FAB_READBACK_OUT[8:0] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 0 load 011 wrong");

  // slice 0 load with coarse only
  a_load_crse0: assert property (s_wr0(3'b100) |=>
    FAB_READBACK_OUT[8:0] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 0 load 100 wrong");

  // slice 0 load with all bits
  a_load_all0: assert property (s_wr0(3'b111) |=>
    FAB_READBACK_OUT[8:0] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 0 load 111 wrong");

  // slice 0 one tap up with wrap
  a_fine_up: assert property (s_wr0(3'b001) |=>
    FAB_READBACK_OUT[8:0] == 9'($past(FAB_READBACK_OUT[8:0]) + 9'h001))
    else $error("slice 0 fine increment wrong");

  // slice 0 one tap down with wrap
  a_fine_down: assert property (s_wr0(3'b010) |=>
    FAB_READBACK_OUT[8:0] == 9'($past(FAB_READBACK_OUT[8:0]) - 9'h001))
    else $error("slice 0 fine decrement wrong");

  a_coarse_up: assert property (s_wr0(3'b101) |=>
    FAB_READBACK_OUT[8:0] == 9'($past(FAB_READBACK_OUT[8:0]) + $past(st_ff.coarse)))
    else $error("slice 0 coarse increment wrong");

  a_coarse_down: assert property (s_wr0(3'b110) |=>
    FAB_READBACK_OUT[8:0] == 9'($past(FAB_READBACK_OUT[8:0]) - $past(st_ff.coarse)))
    else $error("slice 0 coarse decrement wrong");

  a_load_plain1: assert property (s_wr1(3'b000) |=>
    FAB_READBACK_OUT[17:9] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 1 load 000 wrong");

  // slice 1 load with both step bits
  a_load_both1: assert property (s_wr1(3'b011) |=>
    FAB_READBACK_OUT[17:9] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 1 load 011 wrong");

  // slice 1 load with coarse only
  a_load_crse1: assert property (s_wr1(3'b100) |=>
    FAB_READBACK_OUT[17:9] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 1 load 100 wrong");

  // slice 1 load with all bits
  a_load_all1: assert property (s_wr1(3'b111) |=>
    FAB_READBACK_OUT[17:9] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 1 load 111 wrong");

  a_fine_up1: assert property (s_wr1(3'b001) |=>
    FAB_READBACK_OUT[17:9] == 9'($past(FAB_READBACK_OUT[17:9]) + 9'h001))
    else $error("slice 1 fine increment wrong");

  a_fine_down1: assert property (s_wr1(3'b010) |=>
    FAB_READBACK_OUT[17:9] == 9'($past(FAB_READBACK_OUT[17:9]) - 9'h001))
    else $error("slice 1 fine decrement wrong");

  a_coarse_up1: assert property (s_wr1(3'b101) |=>
    FAB_READBACK_OUT[17:9] == 9'($past(FAB_READBACK_OUT[17:9]) + $past(st_ff.coarse)))
    else $error("slice 1 coarse increment wrong");

  a_coarse_down1: assert property (s_wr1(3'b110) |=>
    FAB_READBACK_OUT[17:9] == 9'($past(FAB_READBACK_OUT[17:9]) - $past(st_ff.coarse)))
    else $error("slice 1 coarse decrement wrong");

  a_load_plain2: assert property (s_wr2(3'b000) |=>
    FAB_READBACK_OUT[26:18] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 2 load 000 wrong");

  // slice 2 load with both step bits
  a_load_both2: assert property (s_wr2(3'b011) |=>
    FAB_READBACK_OUT[26:18] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 2 load 011 wrong");

  // slice 2 load with coarse only
  a_load_crse2: assert property (s_wr2(3'b100) |=>
    FAB_READBACK_OUT[26:18] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 2 load 100 wrong");

  // slice 2 load with all bits
  a_load_all2: assert property (s_wr2(3'b111) |=>
    FAB_READBACK_OUT[26:18] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("slice 2 load 111 wrong");

  a_fine_up2: assert property (s_wr2(3'b001) |=>
    FAB_READBACK_OUT[26:18] == 9'($past(FAB_READBACK_OUT[26:18]) + 9'h001))
    else $error("slice 2 fine increment wrong");

  a_fine_down2: assert property (s_wr2(3'b010) |=>
    FAB_READBACK_OUT[26:18] == 9'($past(FAB_READBACK_OUT[26:18]) - 9'h001))
    else $error("slice 2 fine decrement wrong");

  a_coarse_up2: assert property (s_wr2(3'b101) |=>
    FAB_READBACK_OUT[26:18] == 9'($past(FAB_READBACK_OUT[26:18]) + $past(st_ff.coarse)))
    else $error("slice 2 coarse increment wrong");

  a_coarse_down2: assert property (s_wr2(3'b110) |=>
    FAB_READBACK_OUT[26:18] == 9'($past(FAB_READBACK_OUT[26:18]) - $past(st_ff.coarse)))
    else $error("slice 2 coarse decrement wrong");

  // fabric load of lane 0 without a bus write
  a_fabric_load0: assert property (FAB_LOAD_IN.load_en[0] && !(s_wr_take_b(0)) |=>
    FAB_READBACK_OUT[8:0] == $past(FAB_LOAD_IN.load_bus[8:0]))
    else $error("fabric load lane 0 wrong");

  // fabric load of lane 1 without a bus write
  a_fabric_load1: assert property (FAB_LOAD_IN.load_en[1] && !(s_wr_take_b(1)) |=>
    FAB_READBACK_OUT[17:9] == $past(FAB_LOAD_IN.load_bus[17:9]))
    else $error("fabric load lane 1 wrong");

  // fabric load of lane 2 without a bus write
  a_fabric_load: assert property (FAB_LOAD_IN.load_en[2] && !(s_wr_take_b(2)) |=>
    FAB_READBACK_OUT[26:18] == $past(FAB_LOAD_IN.load_bus[26:18]))
    else $error("fabric load lane 2 wrong");

  // bus load beats a fabric load on the same edge
  a_bus_wins: assert property (s_wr_take ##0 (hit[0] && cmd == 3'b000 &&
    FAB_LOAD_IN.load_en[0]) |=> FAB_READBACK_OUT[8:0] == $past(AVS_REQ_IN.writedata[8:0]))
    else $error("bus write lost against fabric load");

  // lane 0 holds when nothing updates it
  a_hold_idle0: assert property (!s_wr_take_b(0) && !FAB_LOAD_IN.load_en[0] |=>
    $stable(FAB_READBACK_OUT[8:0]))
    else $error("lane 0 changed without update");

  // lane 1 holds when nothing updates it
  a_hold_idle1: assert property (!s_wr_take_b(1) && !FAB_LOAD_IN.load_en[1] |=>
    $stable(FAB_READBACK_OUT[17:9]))
    else $error("lane 1 changed without update");

  // lane 2 holds when nothing updates it
  a_hold_idle2: assert property (!s_wr_take_b(2) && !FAB_LOAD_IN.load_en[2] |=>
    $stable(FAB_READBACK_OUT[26:18]))
    else $error("lane 2 changed without update");

  a_unmapped_write: assert property (s_wr_take ##0 (hit == 3'b000 && !hit_coarse &&
    FAB_LOAD_IN.load_en == 3'b000) |=> $stable(FAB_READBACK_OUT))
    else $error("unmapped write changed a lane");

  a_rdata_hold: assert property (!(AVS_REQ_IN.read && !st_ff.ack) |=>
    $stable(AVS_READDATA_OUT))
    else $error("read data changed without capture");

  // a request waits exactly one cycle then is accepted
  a_wait_one: assert property (req && !st_ff.ack |-> AVS_WAITREQUEST_OUT ##1
    (!AVS_WAITREQUEST_OUT || !req))
    else $error("waitrequest timing wrong");

  // a held request after acceptance starts a fresh access
  a_fresh_access: assert property (req && !AVS_WAITREQUEST_OUT |=>
    (AVS_WAITREQUEST_OUT || !req))
    else $error("second access accepted without wait");

  // accepted bus write to one lane, as a plain condition
  function automatic logic s_wr_take_b(input int i);
    return AVS_REQ_IN.write && st_ff.ack && hit[i];
  endfunction

endmodule // nod_regs
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import nod_pkg::*;
  logic clk;
  logic rst;
  nod_avs_req_t req;
  nod_fab_load_t fab;
  logic wreq;
  logic [31:0] rdata;
  logic [26:0] rb;
  logic [8:0] dly [3];
  logic [8:0] coarse;
  logic [8:0] pre;
  logic [8:0] d;
  logic [31:0] got;
  int miscompares;
  int n_compared;

  nod_regs DUT (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .AVS_REQ_IN(req),
    .AVS_WAITREQUEST_OUT(wreq), .AVS_READDATA_OUT(rdata), .FAB_LOAD_IN(fab),
    .FAB_READBACK_OUT(rb));

  // free running clock
  always #5 clk = ~clk;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one access from just after an edge; answer sampled on rising edges only
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    logic w;
    req <= '{read: rd, write: !rd, address: a, writedata: wd};
    do begin
      @(posedge clk);
      w = wreq;
      rv = rdata;
    end while (w);
  endtask

  function automatic logic [7:0] addr(input int s);
    return 8'h2c + 8'(4 * s);
  endfunction

  // expected delay after a command write
  function automatic logic [8:0] step(input logic [2:0] c, input logic [8:0] cur,
                                     input logic [8:0] v);
    case (c)
      3'b001: return cur + 9'h001;
      3'b010: return cur - 9'h001;
      3'b101: return cur + coarse;
      3'b110: return cur - coarse;
      default: return v;
    endcase
  endfunction

  task automatic verify(input int s);
    bus(1'b1, addr(s), 32'h0, got);
    check(got, {23'h0, dly[s]});
    check({5'h0, rb}, {5'h0, dly[2], dly[1], dly[0]});
  endtask

  // watchdog
  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    fab = '0;
    miscompares = 0;
    n_compared = 0;
    coarse = 9'h008;
    for (int i = 0; i < 3; i++) dly[i] = 9'h000;
    void'($urandom(60108));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, 8'h80, 32'h0, got);
    check(got, 32'h0);
    for (int s = 0; s < 3; s++) verify(s);
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 8; c++) begin
        for (int t = 0; t < 4; t++) begin
          pre = (t == 0) ? ((c == 1 || c == 5) ? 9'h1ff : 9'h000) : 9'($urandom);
          if (t == 2) begin
            coarse = 9'($urandom);
            bus(1'b0, 8'h40, {23'h0, coarse}, got);
            bus(1'b1, 8'h40, 32'h0, got);
            check(got, {23'h0, coarse});
          end
          bus(1'b0, addr(s), {23'h0, pre}, got);
          dly[s] = pre;
          d = 9'($urandom);
          bus(1'b0, addr(s), {16'h0, c[0], c[1], c[2], 4'h0, d}, got);
          dly[s] = step(3'(c), dly[s], d);
          verify(s);
        end
      end
    end
    bus(1'b0, 8'h80, 32'h0000_01ff, got);
    for (int s = 0; s < 3; s++) verify(s);
    // fabric loads per lane
    for (int s = 0; s < 3; s++) begin
      d = 9'($urandom);
      req <= '0;
      fab <= '{load_en: 3'(1 << s), load_bus: {3{d}}};
      @(posedge clk);
      fab <= '0;
      dly[s] = d;
      @(posedge clk);
      verify(s);
      // bus load and fabric load on one edge: the bus wins
      fab <= '{load_en: 3'(1 << s), load_bus: {3{~d}}};
      bus(1'b0, addr(s), {23'h0, d ^ 9'h0a5}, got);
      fab <= '0;
      dly[s] = d ^ 9'h0a5;
      verify(s);
    end
    final_report();
  end
endmodule // tb_top
`default_nettype wire
